// ### core/pc_card_socket_signaling.sv
// socket side control of a pc card host: 16-bit strobes and cardbus clock
// assumes card pins arrive unsynchronised; host side is on I_CORE_CLK
`include "pc_card_params.svh"
`timescale 1ns/1ns

// What this block does
// - attribute select stays high during every common memory access
// - attribute select low routes memory strobes to attribute, io to io
// - card reset output hard-resets a 16-bit card while asserted
// - both voltage sense lines are judged together for card voltage
// - card wait request stretches the cycle; cycle never ends meanwhile
// - write strobe clocks write data into memory cards
// - for an io card the write-protect input means 16-bit port
// - cardbus signals sampled on card clock rise, except control lines
// - card clock at bus rate, may slow or stop, stopped means low
// - device uses clock-run to announce a lower card clock
// - during cardbus reset card floats and device drives valid levels
// - cardbus reset asserts anytime, releases only on card clock rise
// - output enable low makes memory card drive read data
// - io read strobe for io reads, io write strobe low latches writes
module pc_card_socket_signaling (
    // clock and reset
    input wire logic I_CORE_CLK,
    input wire logic I_RESET,
    // host side
    input wire logic i_cardbus_mode,
    input wire logic i_io_card,
    input wire logic i_card_reset_req,
    input wire logic i_clk_slow_req,
    input wire logic i_clk_stop,
    input wire logic i_req_valid,
    input wire pc_card_pkg::req_s i_req,
    output logic o_req_ready,
    output logic o_done,
    output logic [15:0] o_rdata,
    output logic o_write_protect,
    output logic o_port_is_16bit,
    output logic o_low_voltage_card,
    // 16-bit card pins
    output logic O_REG_N,
    output logic O_CARD_RESET,
    output logic O_OE_N,
    output logic O_WE_N,
    output logic O_IO_READ_STROBE_N,
    output logic O_IO_WRITE_STROBE_N,
    output logic [15:0] O_DATA,
    output logic O_DATA_OE,
    input wire logic [15:0] I_DATA,
    input wire logic I_WAIT_N,
    input wire logic I_WP,
    input wire logic [1:0] I_VS,
    // cardbus pins
    output logic O_CARD_BUS_CLOCK,
    output logic O_CARD_BUS_RESET_N,
    output logic O_CLKRUN_N,
    output logic O_CLKRUN_OE,
    input wire logic I_CLKRUN_N
);

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    localparam logic [3:0] SETUP_C = 4'(`SETUP_MIN_CYC);
    localparam logic [3:0] STROBE_C = 4'(`STROBE_MIN_CYC);
    localparam logic [3:0] TAIL_C = 4'(`WAIT_TAIL_CYC);
    localparam logic [3:0] NOTICE_C = 4'(`CLKRUN_CYC);

    logic [`SYNC_W-1:0] sync1_ff;
    logic [`SYNC_W-1:0] sync2_ff;

    // clkrun and vs are not card-clock sampled, so plain two-flop sync
    always_ff @(posedge I_CORE_CLK) begin
        sync1_ff <= {I_WAIT_N, I_WP, I_VS, I_CLKRUN_N, I_DATA};
        sync2_ff <= sync1_ff;
    end

    wire card_wait = ~sync2_ff[20];
    wire wp_s = sync2_ff[19];
    wire [1:0] vs_s = sync2_ff[18:17];
    wire clkrun_in_n = sync2_ff[16];
    wire [15:0] data_s = sync2_ff[15:0];

    // ------------------------------------------------------------
    // sense lines and card reset
    // ------------------------------------------------------------
    logic wp_ff;
    logic p16_ff;
    logic lowv_ff;
    logic card_rst_ff;

    always_ff @(posedge I_CORE_CLK) begin
        if (I_RESET) begin
            wp_ff <= 1'b0;
            p16_ff <= 1'b0;
            lowv_ff <= 1'b0;
            card_rst_ff <= 1'b1;
        end else begin
            wp_ff <= wp_s & ~i_io_card;
            p16_ff <= wp_s & i_io_card;
            lowv_ff <= ~(vs_s[0] & vs_s[1]);
            card_rst_ff <= i_card_reset_req & ~i_cardbus_mode;
        end
    end

    assign o_write_protect = wp_ff;
    assign o_port_is_16bit = p16_ff;
    assign o_low_voltage_card = lowv_ff;
    assign O_CARD_RESET = card_rst_ff;

    // ------------------------------------------------------------
    // 16-bit access sequencer
    // ------------------------------------------------------------
    pc_card_pkg::acc_state_e acc_ff;
    pc_card_pkg::acc_state_e nxt_acc;
    pc_card_pkg::req_s req_ff;
    logic [3:0] acnt_ff;
    logic [15:0] rdata_ff;

    wire acc_idle = (acc_ff == pc_card_pkg::AC_IDLE);
    wire strobe_on = (acc_ff == pc_card_pkg::AC_STROBE) ||
                     (acc_ff == pc_card_pkg::AC_TAIL);
    wire acnt_zero = (acnt_ff == 4'h0);
    wire is_io = (req_ff.space == pc_card_pkg::SP_IO);
    wire can_start = i_req_valid & ~i_cardbus_mode & ~card_rst_ff;

    assign o_req_ready = acc_idle & ~i_cardbus_mode & ~card_rst_ff;

    always_comb begin
        nxt_acc = acc_ff;
        case (acc_ff)
            pc_card_pkg::AC_IDLE: begin
                if (can_start) begin
                    nxt_acc = pc_card_pkg::AC_SETUP;
                end
            end
            pc_card_pkg::AC_SETUP: begin
                if (acnt_zero) begin
                    nxt_acc = pc_card_pkg::AC_STROBE;
                end
            end
            pc_card_pkg::AC_STROBE: begin
                // wait is seen late through the sync, so a minimum width
                // gives the card time to answer before we look at it
                if (acnt_zero && !card_wait) begin
                    nxt_acc = pc_card_pkg::AC_TAIL;
                end
            end
            pc_card_pkg::AC_TAIL: begin
                if (card_wait) begin
                    nxt_acc = pc_card_pkg::AC_STROBE;
                end else if (acnt_zero) begin
                    nxt_acc = pc_card_pkg::AC_DONE;
                end
            end
            pc_card_pkg::AC_DONE: nxt_acc = pc_card_pkg::AC_IDLE;
            default: nxt_acc = pc_card_pkg::AC_IDLE;
        endcase
    end

    always_ff @(posedge I_CORE_CLK) begin
        if (I_RESET) begin
            acc_ff <= pc_card_pkg::AC_IDLE;
            req_ff <= '0;
            acnt_ff <= 4'h0;
            rdata_ff <= 16'h0000;
        end else begin
            acc_ff <= nxt_acc;
            if (acc_idle && can_start) begin
                req_ff <= i_req;
            end
            if (nxt_acc != acc_ff) begin
                acnt_ff <= (nxt_acc == pc_card_pkg::AC_SETUP) ? SETUP_C - 4'h1 :
                           (nxt_acc == pc_card_pkg::AC_STROBE) ?
                           STROBE_C - 4'h1 : TAIL_C - 4'h1;
            end else if (!acnt_zero) begin
                acnt_ff <= acnt_ff - 4'h1;
            end
            if (acc_ff == pc_card_pkg::AC_TAIL && nxt_acc ==
                pc_card_pkg::AC_DONE && !req_ff.is_write) begin
                rdata_ff <= data_s;
            end
        end
    end

    assign o_done = (acc_ff == pc_card_pkg::AC_DONE);
    assign o_rdata = rdata_ff;
    // common memory keeps the select high; attribute and io pull it low
    assign O_REG_N = acc_idle | (req_ff.space == pc_card_pkg::SP_COMMON);
    assign O_OE_N = ~(strobe_on & ~is_io & ~req_ff.is_write);
    assign O_WE_N = ~(strobe_on & ~is_io & req_ff.is_write);
    assign O_IO_READ_STROBE_N = ~(strobe_on & is_io & ~req_ff.is_write);
    assign O_IO_WRITE_STROBE_N = ~(strobe_on & is_io & req_ff.is_write);
    assign O_DATA = req_ff.wdata;
    assign O_DATA_OE = ~acc_idle & req_ff.is_write;

    // ------------------------------------------------------------
    // cardbus clock, clock-run and reset
    // ------------------------------------------------------------
    pc_card_pkg::clk_state_e ck_ff;
    pc_card_pkg::clk_state_e nxt_ck;
    logic [3:0] ccnt_ff;
    logic [3:0] half_ff;
    logic card_bus_clock_ff;
    logic card_bus_reset_n_ff;

    wire cb_rst = I_RESET | ~i_cardbus_mode | i_card_reset_req;
    wire ccnt_zero = (ccnt_ff == 4'h0);
    wire ck_low = (ck_ff == pc_card_pkg::CK_LOW);
    wire [3:0] half_lim = ck_low ? `CARD_BUS_CLOCK_HALF_SLOW : `CARD_BUS_CLOCK_HALF_FAST;
    wire half_hit = (half_ff >= half_lim - 4'h1);
    // a stop only lands on a low phase so the clock parks low
    wire hold_low = ~i_cardbus_mode | (ck_low & i_clk_stop & ~card_bus_clock_ff);
    wire toggle = half_hit & ~hold_low;
    wire card_bus_clock_rise = toggle & ~card_bus_clock_ff;

    always_comb begin
        nxt_ck = ck_ff;
        case (ck_ff)
            pc_card_pkg::CK_FAST: begin
                if (i_clk_slow_req && card_bus_reset_n_ff) begin
                    nxt_ck = pc_card_pkg::CK_NOTIFY;
                end
            end
            pc_card_pkg::CK_NOTIFY: begin
                if (ccnt_zero) begin
                    nxt_ck = pc_card_pkg::CK_CHECK;
                end
            end
            pc_card_pkg::CK_CHECK: begin
                if (!clkrun_in_n) begin
                    nxt_ck = pc_card_pkg::CK_FAST;
                end else if (ccnt_zero) begin
                    nxt_ck = pc_card_pkg::CK_LOW;
                end
            end
            pc_card_pkg::CK_LOW: begin
                if (!clkrun_in_n || !i_clk_slow_req) begin
                    nxt_ck = pc_card_pkg::CK_FAST;
                end
            end
            default: nxt_ck = pc_card_pkg::CK_FAST;
        endcase
        if (!card_bus_reset_n_ff) begin
            nxt_ck = pc_card_pkg::CK_FAST;
        end
    end

    always_ff @(posedge I_CORE_CLK) begin
        if (I_RESET) begin
            ck_ff <= pc_card_pkg::CK_FAST;
            ccnt_ff <= 4'h0;
            half_ff <= 4'h0;
            card_bus_clock_ff <= 1'b0;
        end else begin
            ck_ff <= nxt_ck;
            if (nxt_ck != ck_ff) begin
                ccnt_ff <= NOTICE_C - 4'h1;
            end else if (!ccnt_zero) begin
                ccnt_ff <= ccnt_ff - 4'h1;
            end
            half_ff <= (half_hit || hold_low) ? 4'h0 : half_ff + 4'h1;
            if (toggle) begin
                card_bus_clock_ff <= ~card_bus_clock_ff;
            end
        end
    end

    // assertion is immediate; release waits for a card clock rise
    always_ff @(posedge I_CORE_CLK) begin
        if (cb_rst) begin
            card_bus_reset_n_ff <= 1'b0;
        end else if (card_bus_clock_rise) begin
            card_bus_reset_n_ff <= 1'b1;
        end
    end

    assign O_CARD_BUS_CLOCK = card_bus_clock_ff;
    assign O_CARD_BUS_RESET_N = card_bus_reset_n_ff;
    // during reset we drive clock-run high so the line never floats
    assign O_CLKRUN_OE = ~card_bus_reset_n_ff | (ck_ff == pc_card_pkg::CK_NOTIFY);
    assign O_CLKRUN_N = 1'b1;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge I_CORE_CLK); endclocking
    default disable iff (I_RESET);

    a_reg_common_high: assert property (strobe_on && req_ff.space ==
        pc_card_pkg::SP_COMMON |-> O_REG_N) else $error("select low");
    a_reg_attr_io: assert property (strobe_on && req_ff.space !=
        pc_card_pkg::SP_COMMON |-> !O_REG_N) else $error("select high");
    a_card_reset: assert property (i_card_reset_req && !i_cardbus_mode
        |=> O_CARD_RESET) else $error("no card reset");
    a_wait_holds: assert property (strobe_on && card_wait |=> strobe_on)
        else $error("strobe ended in wait");
    a_tail_fixed: assert property ($fell(card_wait) && strobe_on &&
        acnt_zero |-> strobe_on [*2]) else $error("tail too short");
    a_we_write: assert property (!O_WE_N |-> req_ff.is_write && !is_io)
        else $error("stray write strobe");
    a_oe_read: assert property ($fell(O_OE_N) |-> O_WE_N && O_IO_READ_STROBE_N)
        else $error("read strobe clash");
    a_io_strobes: assert property (!O_IO_READ_STROBE_N || !O_IO_WRITE_STROBE_N |-> !O_REG_N &&
        O_OE_N && O_WE_N) else $error("io strobe clash");
    a_port16: assert property (i_io_card && $stable(i_io_card) |=>
        !o_write_protect) else $error("wp in io mode");
    a_stop_low: assert property (ck_low && i_clk_stop && !card_bus_clock_ff |=>
        !O_CARD_BUS_CLOCK) else $error("stopped clock high");
    a_notify_drive: assert property (ck_ff == pc_card_pkg::CK_NOTIFY |->
        O_CLKRUN_OE && O_CLKRUN_N) else $error("no clkrun notice");
    a_card_bus_reset_drive: assert property (!O_CARD_BUS_RESET_N |-> O_CLKRUN_OE)
        else $error("lines float in reset");
    a_card_bus_reset_sync: assert property ($rose(O_CARD_BUS_RESET_N) |-> $past(card_bus_clock_rise))
        else $error("reset release off clock");

    c_mem_read: cover property (o_done && !req_ff.is_write && !is_io);
    c_io_wait: cover property (strobe_on && card_wait && is_io);
    c_clk_slow: cover property (ck_low && O_CARD_BUS_CLOCK);
    c_card_bus_reset_rel: cover property ($rose(O_CARD_BUS_RESET_N));

endmodule // pc_card_socket_signaling

// ### dv/pc_card_partner.sv
// card model at the socket pins: 16-bit card and cardbus clock-run side
// assumes active-low strobes and a pull-up on the clock-run line
`timescale 1ns/1ns
module pc_card_partner (
    // clock
    input wire logic i_clk,
    // socket strobes and data from the host
    input wire logic i_oe_n,
    input wire logic i_we_n,
    input wire logic i_io_read_strobe_n,
    input wire logic i_io_write_strobe_n,
    input wire logic [15:0] i_wdata,
    // cardbus control from the host
    input wire logic i_card_bus_reset_n,
    input wire logic i_clkrun_n,
    input wire logic i_clkrun_oe,
    // scenario controls
    input wire logic [15:0] i_rd_val,
    input wire logic [3:0] i_wait_cyc,
    input wire logic i_object,
    // card outputs
    output logic [15:0] o_data,
    output logic o_wait_n,
    output logic o_clkrun_n,
    output logic [15:0] o_last_wr
);
    logic [3:0] cnt_ff = 4'h0;
    logic [15:0] last_ff = 16'h0;
    wire rd_on = !i_oe_n || !i_io_read_strobe_n;
    wire any_on = rd_on || !i_we_n || !i_io_write_strobe_n;

    always @(posedge i_clk) begin
        cnt_ff <= !any_on ? 4'h0 : (cnt_ff == 4'hf) ? cnt_ff : cnt_ff + 4'h1;
        if (rd_on) last_ff <= i_rd_val;
    end

    // a released bus shows the inverse, so stale data never passes
    assign o_data = rd_on ? i_rd_val : ~last_ff;
    assign o_wait_n = !(any_on && cnt_ff < i_wait_cyc);
    // card may only pull low out of reset; pull-up otherwise
    assign o_clkrun_n = i_clkrun_oe ? i_clkrun_n :
                        !(i_object && i_card_bus_reset_n);

    always @(posedge i_we_n or posedge i_io_write_strobe_n) begin
        o_last_wr <= i_wdata;
    end
endmodule // pc_card_partner

// ### dv/testbench.sv
// self-checking bench for the pc card socket signalling block
// assumes the card model of pc_card_partner.sv on the socket pins
`timescale 1ns/1ns
module testbench;
    logic clk = 1'b0, rst = 1'b1, mode = 1'b0, io_card = 1'b0;
    logic rst_req = 1'b0, slow = 1'b0, stop = 1'b0, valid = 1'b0;
    logic wp = 1'b0, object = 1'b0;
    logic [1:0] vs = 2'h3;
    logic [3:0] wcyc = 4'h0;
    logic [15:0] rd_val = 16'h0;
    pc_card_pkg::req_s req = '0;
    logic ready, done, wprot, p16, lowv, reg_n, crd_rst, oe_n, we_n, doe;
    logic io_read_strobe_n, io_write_strobe_n, card_bus_clock, card_bus_reset_n, ckr_n, ckr_oe, wait_n, ckr_in;
    logic [15:0] rdata, dout, din, last_wr;
    int n_mismatch = 0, checks_done = 0;
    always #25 clk = ~clk;

    pc_card_socket_signaling DUT (.I_CORE_CLK(clk), .I_RESET(rst),
        .i_cardbus_mode(mode), .i_io_card(io_card), .i_card_reset_req(rst_req),
        .i_clk_slow_req(slow), .i_clk_stop(stop), .i_req_valid(valid),
        .i_req(req), .o_req_ready(ready), .o_done(done), .o_rdata(rdata),
        .o_write_protect(wprot), .o_port_is_16bit(p16),
        .o_low_voltage_card(lowv), .O_REG_N(reg_n), .O_CARD_RESET(crd_rst),
        .O_OE_N(oe_n), .O_WE_N(we_n), .O_IO_READ_STROBE_N(io_read_strobe_n), .O_IO_WRITE_STROBE_N(io_write_strobe_n),
        .O_DATA(dout), .O_DATA_OE(doe), .I_DATA(din), .I_WAIT_N(wait_n),
        .I_WP(wp), .I_VS(vs), .O_CARD_BUS_CLOCK(card_bus_clock), .O_CARD_BUS_RESET_N(card_bus_reset_n),
        .O_CLKRUN_N(ckr_n), .O_CLKRUN_OE(ckr_oe), .I_CLKRUN_N(ckr_in));
    pc_card_partner card (.i_clk(clk), .i_oe_n(oe_n), .i_we_n(we_n),
        .i_io_read_strobe_n(io_read_strobe_n), .i_io_write_strobe_n(io_write_strobe_n), .i_wdata(dout),
        .i_card_bus_reset_n(card_bus_reset_n), .i_clkrun_n(ckr_n), .i_clkrun_oe(ckr_oe),
        .i_rd_val(rd_val), .i_wait_cyc(wcyc), .i_object(object),
        .o_data(din), .o_wait_n(wait_n), .o_clkrun_n(ckr_in),
        .o_last_wr(last_wr));

    task automatic tick;
        @(posedge clk);
        #1;
    endtask
    task automatic close_out;
        $display("mismatches %0d checks %0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic hang;
        n_mismatch++;
        close_out();
    endtask
    task automatic chk(input string nm, input logic [15:0] e, g);
        checks_done++;
        if (g !== e) begin
            $display("[ERR] %s expected %h seen %h", nm, e, g);
            n_mismatch++;
        end
    endtask
    task automatic pass(input int k);
        repeat (k) tick();
    endtask

    // one host access; strobe choice, select and stretch judged per cycle
    task automatic access(input int i, input logic [3:0] w);
        int n, lo;
        logic bad, dbad;
        logic [3:0] seen;
        n = 0;
        lo = 0;
        bad = 1'b0;
        dbad = 1'b0;
        seen = 4'h0;
        wcyc = w;
        rd_val = 16'h5a00 | 16'(i);
        req = '{i[0], pc_card_pkg::space_e'(i >> 1), 16'hc300 | 16'(i)};
        valid = 1'b1;
        while (ready !== 1'b1 && n < 50) begin
            tick();
            n++;
        end
        tick();
        valid = 1'b0;
        while (done !== 1'b1 && n < 200) begin
            seen |= ~{oe_n, we_n, io_read_strobe_n, io_write_strobe_n};
            if ((oe_n & we_n & io_read_strobe_n & io_write_strobe_n) !== 1'b1) begin
                lo++;
                if (reg_n !== ((i >> 1) == 0)) bad = 1'b1;
                if (doe !== i[0]) dbad = 1'b1;
            end
            if ((i >> 1) == 0 && reg_n !== 1'b1) bad = 1'b1;
            tick();
            n++;
        end
        if (n >= 200) hang();
        chk("strobe_kind", 4'h8 >> (2 * (i >> 2) + i % 2), seen);
        chk("select_level", 16'h0, bad);
        chk("data_drive", 16'h0, dbad);
        chk("strobe_min", 16'h1, lo >= (w > 6 ? w + 2 : 8));
        chk("strobe_max", 16'h1, lo <= w + 8);
        if (i[0]) chk("write_data", req.wdata, last_wr);
        else chk("read_data", rd_val, rdata);
        tick();
        chk("done_pulse", 16'h0, done);
    endtask

    task automatic t_access;
        // back to back, every space both ways, two with a long wait
        for (int i = 0; i < 6; i++) access(i, (i == 3 || i == 5) ? 12 : 0);
        $display("test access finished");
    endtask

    task automatic t_sense;
        wp = 1'b1;
        pass(4);
        chk("wp_mem", 16'h1, wprot);
        chk("p16_mem", 16'h0, p16);
        io_card = 1'b1;
        pass(4);
        chk("p16_io", 16'h1, p16);
        chk("wp_io", 16'h0, wprot);
        for (int v = 0; v < 4; v++) begin
            vs = 2'(v);
            pass(4);
            chk("low_volt", 16'(v != 3), lowv);
        end
        $display("test sense finished");
    endtask

    task automatic t_card_reset;
        rst_req = 1'b1;
        pass(2);
        chk("card_reset_on", 16'h1, crd_rst);
        chk("ready_in_reset", 16'h0, ready);
        rst_req = 1'b0;
        pass(2);
        chk("card_reset_off", 16'h0, crd_rst);
        $display("test card reset finished");
    endtask

    task automatic half(input string nm, input int e);
        int n, h;
        n = 0;
        h = 0;
        while (card_bus_clock !== 1'b0 && n < 40) begin tick(); n++; end
        while (card_bus_clock !== 1'b1 && n < 40) begin tick(); n++; end
        while (card_bus_clock === 1'b1 && n < 40) begin tick(); n++; h++; end
        if (n >= 40) hang();
        chk(nm, 16'(e), 16'(h));
    endtask

    task automatic t_cardbus;
        int n;
        logic seen;
        mode = 1'b1;
        rst_req = 1'b1;
        pass(2);
        chk("card_bus_reset_on", 16'h0, card_bus_reset_n);
        chk("ready_cardbus", 16'h0, ready);
        rst_req = 1'b0;
        n = 0;
        while (card_bus_reset_n !== 1'b1 && n < 20) begin tick(); n++; end
        chk("card_bus_reset_release_edge", 16'h1, card_bus_clock);
        half("half_fast", 1);
        slow = 1'b1;
        seen = 1'b0;
        for (int k = 0; k < 4; k++) begin tick(); seen |= ckr_oe; end
        chk("clkrun_notice", 16'h1, seen);
        pass(8);
        half("half_slow", 4);
        object = 1'b1;
        pass(10);
        half("half_objected", 1);
        object = 1'b0;
        stop = 1'b1;
        pass(20);
        seen = 1'b0;
        for (int k = 0; k < 20; k++) begin tick(); seen |= card_bus_clock; end
        chk("clock_stopped_low", 16'h0, seen);
        $display("test cardbus finished");
    endtask

    initial begin
        pass(4);
        chk("reset_out", 16'h1, crd_rst);
        chk("idle_strobes", 16'hf, {oe_n, we_n, io_read_strobe_n, io_write_strobe_n});
        rst = 1'b0;
        t_access();
        t_sense();
        t_card_reset();
        t_cardbus();
        close_out();
    end
endmodule // testbench

// ### pkg/pc_card_params.svh
// offsets-free constant set for the pc card socket signalling block
// assumes a 20 MHz core clock; strobe, setup, tail and clock-run counts derive from the times below
`ifndef PC_CARD_PARAMS_SVH
`define PC_CARD_PARAMS_SVH

`define CORE_CLK_MHZ 20
// least strobe width and setup before a strobe, in ns
`define STROBE_MIN_NS 300
`define SETUP_MIN_NS 100
// strobe tail after the card releases its wait request, in ns
`define WAIT_TAIL_NS 100
// clock-run notice and check windows, in ns
`define CLKRUN_NOTICE_NS 200
`define STROBE_MIN_CYC (((`STROBE_MIN_NS * `CORE_CLK_MHZ) + 999) / 1000)
`define SETUP_MIN_CYC (((`SETUP_MIN_NS * `CORE_CLK_MHZ) + 999) / 1000)
`define WAIT_TAIL_CYC (((`WAIT_TAIL_NS * `CORE_CLK_MHZ) + 999) / 1000)
`define CLKRUN_CYC (((`CLKRUN_NOTICE_NS * `CORE_CLK_MHZ) + 999) / 1000)
// card clock half periods in core cycles: full rate and slowed rate
`define CARD_BUS_CLOCK_HALF_FAST 4'h1
`define CARD_BUS_CLOCK_HALF_SLOW 4'h4
// synchroniser width: wait, wp, vs pair, clkrun, 16 data bits
`define SYNC_W 21

`endif

// ### pkg/pc_card_pkg.sv
// types shared by the pc card socket signalling block
// assumes pc_card_params.svh supplies the numeric constants
package pc_card_pkg;

    typedef enum logic [1:0] {
        SP_COMMON = 2'h0,
        SP_ATTR = 2'h1,
        SP_IO = 2'h2
    } space_e;

    typedef struct packed {
        logic is_write;
        space_e space;
        logic [15:0] wdata;
    } req_s;

    typedef enum logic [4:0] {
        AC_IDLE = 5'h01,
        AC_SETUP = 5'h02,
        AC_STROBE = 5'h04,
        AC_TAIL = 5'h08,
        AC_DONE = 5'h10
    } acc_state_e;

    typedef enum logic [3:0] {
        CK_FAST = 4'h1,
        CK_NOTIFY = 4'h2,
        CK_CHECK = 4'h4,
        CK_LOW = 4'h8
    } clk_state_e;

endpackage
